// >>> fbio_defs.svh
// Register offsets, field positions, codes and reset values of the state registers
`ifndef FBIO_DEFS_SVH
`define FBIO_DEFS_SVH

`define FBIO_OFS_CTRL 16'h0120
`define FBIO_OFS_STAT 16'h0130
`define FBIO_OFS_CODE 16'h0134
`define FBIO_OFS_INPUT 16'h4000
`define FBIO_OFS_DIAG 16'h4001
`define FBIO_OFS_OUTPUT 16'h5000
`define FBIO_OFS_SAFE_MODE 16'h2100
`define FBIO_OFS_SAFE_VAL 16'h2102

`define FBIO_STATE_LSB 0
`define FBIO_STATE_MSB 3
`define FBIO_FLAG_BIT 4

`define FBIO_CODE_INIT 4'h1
`define FBIO_CODE_PREOP 4'h2
`define FBIO_CODE_BOOT 4'h3
`define FBIO_CODE_SAFEOP 4'h4
`define FBIO_CODE_OP 4'h8

`define FBIO_ERR_NONE 16'h0000
`define FBIO_ERR_INVALID 16'h0011
`define FBIO_ERR_UNKNOWN 16'h0012

`define FBIO_DIAG_MASK 32'h0000_003F
`define FBIO_ENTRY_COUNT 8'h01

`define FBIO_SAFE_ZERO 2'h0
`define FBIO_SAFE_ONE 2'h1
`define FBIO_SAFE_HOLD 2'h2
`define FBIO_SAFE_PATTERN 2'h3

`define FBIO_RST_CTRL 16'h0001
`define FBIO_RST_CODE 16'h0000
`define FBIO_RST_OUT 8'h00

`endif

// >>> fbio_pkg.sv
// Types shared by the fieldbus I/O state register block
`default_nettype none
package fbio_pkg;
    typedef enum logic [2:0] {
        FBIO_ST_INIT,
        FBIO_ST_PREOP,
        FBIO_ST_BOOT,
        FBIO_ST_SAFEOP,
        FBIO_ST_OP
    } fbio_state_t;
endpackage
`default_nettype wire

// >>> fbio_regs.sv
// State registers, process image and output substitution of the fieldbus I/O slave
`include "fbio_defs.svh"
`default_nettype none
module fbio_regs
    import fbio_pkg::*;
#(
    parameter int IO_WIDTH = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port of the master
    input wire logic reg_wr,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [7:0] reg_subidx,
    output logic [31:0] reg_rdata,
    // Local state requests above pre-operational
    input wire logic go_safeop,
    input wire logic go_op,
    // Field side
    input wire logic [IO_WIDTH-1:0] din,
    input wire logic [5:0] diag_flags,
    output logic [IO_WIDTH-1:0] dout
);
    // State, change flag, error code and control copy
    fbio_state_t state_q, state_d;
    logic flag_q, flag_d;
    logic [15:0] code_q, code_d;
    logic [15:0] ctrl_q, ctrl_d;

    // Output byte, substitute configuration and pin drive
    logic [IO_WIDTH-1:0] out_q, out_d, safe_val_q, safe_val_d, last_q, last_d, dout_d;
    logic [1:0] safe_mode_q, safe_mode_d;
    logic [IO_WIDTH-1:0] subst;

    // Decoded state code, requested state, write strobes and diagnostic word
    logic [3:0] state_code;
    logic [3:0] req;
    logic ctrl_hit, out_hit, mode_hit, val_hit;
    logic [31:0] diag_word;

    // Status code for the current state
    always_comb begin
        case (state_q)
            FBIO_ST_INIT: state_code = `FBIO_CODE_INIT;
            FBIO_ST_PREOP: state_code = `FBIO_CODE_PREOP;
            FBIO_ST_BOOT: state_code = `FBIO_CODE_BOOT;
            FBIO_ST_SAFEOP: state_code = `FBIO_CODE_SAFEOP;
            FBIO_ST_OP: state_code = `FBIO_CODE_OP;
            default: state_code = `FBIO_CODE_INIT;
        endcase
    end

    // Requested state field of a control write
    assign req = reg_wdata[`FBIO_STATE_MSB:`FBIO_STATE_LSB];

    // Write strobes per object; substitute configuration only lands in pre-operational
    assign ctrl_hit = reg_wr && (reg_addr == `FBIO_OFS_CTRL);
    assign out_hit = reg_wr && (reg_addr == `FBIO_OFS_OUTPUT);
    assign mode_hit = reg_wr && (state_q == FBIO_ST_PREOP) && (reg_addr == `FBIO_OFS_SAFE_MODE);
    assign val_hit = reg_wr && (state_q == FBIO_ST_PREOP) && (reg_addr == `FBIO_OFS_SAFE_VAL)
        && (reg_subidx == 8'h01);

    // Diagnostic word with its reserved bits forced low
    assign diag_word = {26'h0, diag_flags} & `FBIO_DIAG_MASK;

    // Slave state machine, change flag and error code
    always_comb begin
        state_d = state_q;
        flag_d = flag_q;
        code_d = code_q;
        ctrl_d = ctrl_q;
        // A master control write outranks a local request in the same cycle; that local request is dropped
        if (ctrl_hit) begin
            ctrl_d = reg_wdata;
            // Clear first, so a failing request in the same write raises the flag again
            if (reg_wdata[`FBIO_FLAG_BIT]) begin
                flag_d = 1'b0;
            end
            case (req)
                `FBIO_CODE_INIT: begin
                    state_d = FBIO_ST_INIT;
                    code_d = `FBIO_ERR_NONE;
                end
                `FBIO_CODE_PREOP: begin
                    // Bootstrap is left through init only; the flag tells the master it landed elsewhere
                    if (state_q == FBIO_ST_BOOT) begin
                        state_d = FBIO_ST_INIT;
                        flag_d = 1'b1;
                    end else begin
                        state_d = FBIO_ST_PREOP;
                        code_d = `FBIO_ERR_NONE;
                    end
                end
                `FBIO_CODE_BOOT: begin
                    if (state_q == FBIO_ST_INIT || state_q == FBIO_ST_BOOT) begin
                        state_d = FBIO_ST_BOOT;
                        code_d = `FBIO_ERR_NONE;
                    end else begin
                        flag_d = 1'b1;
                        code_d = `FBIO_ERR_INVALID;
                    end
                end
                default: begin
                    // Codes 0 and 4 to 15 are unknown on this path: state held, flag and code raised
                    flag_d = 1'b1;
                    code_d = `FBIO_ERR_UNKNOWN;
                end
            endcase
        end else if (go_safeop && state_q == FBIO_ST_PREOP) begin
            // Local requests climb one step at a time and flag the change for the master
            state_d = FBIO_ST_SAFEOP;
            flag_d = 1'b1;
        end else if (go_op && state_q == FBIO_ST_SAFEOP) begin
            state_d = FBIO_ST_OP;
            flag_d = 1'b1;
        end
    end

    // Output byte, substitute mode and pattern
    always_comb begin
        out_d = out_q;
        safe_mode_d = safe_mode_q;
        safe_val_d = safe_val_q;
        // Hold value tracks the byte only while operational, so it keeps what the pins last showed in operational
        last_d = (state_q == FBIO_ST_OP) ? out_q : last_q;
        if (out_hit) begin
            out_d = reg_wdata[IO_WIDTH-1:0];
        end
        if (mode_hit) begin
            safe_mode_d = reg_wdata[1:0];
        end
        if (val_hit) begin
            safe_val_d = reg_wdata[IO_WIDTH-1:0];
        end
    end

    // Substitute level per output, bit 7 for output 8 down to bit 0 for output 1
    for (genvar gi = 0; gi < IO_WIDTH; gi++) begin : g_subst
        assign subst[gi] = (safe_mode_q == `FBIO_SAFE_ZERO) ? 1'b0
            : (safe_mode_q == `FBIO_SAFE_ONE) ? 1'b1
            : (safe_mode_q == `FBIO_SAFE_HOLD) ? last_q[gi]
            : safe_val_q[gi];
    end

    // Pin drive: the output byte only while operational, the substitute in every other state
    always_comb begin
        dout_d = subst;
        if (state_q == FBIO_ST_OP) begin
            dout_d = out_q;
        end
    end

    // State machine registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= FBIO_ST_INIT;
            flag_q <= 1'b0;
            code_q <= `FBIO_RST_CODE;
            ctrl_q <= `FBIO_RST_CTRL;
        end else begin
            state_q <= state_d;
            flag_q <= flag_d;
            code_q <= code_d;
            ctrl_q <= ctrl_d;
        end
    end

    // Output byte and substitute configuration registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= IO_WIDTH'(`FBIO_RST_OUT);
            safe_val_q <= IO_WIDTH'(`FBIO_RST_OUT);
            last_q <= IO_WIDTH'(`FBIO_RST_OUT);
            safe_mode_q <= `FBIO_SAFE_ZERO;
        end else begin
            out_q <= out_d;
            safe_val_q <= safe_val_d;
            last_q <= last_d;
            safe_mode_q <= safe_mode_d;
        end
    end

    // Pins come from a flop so a mode or state change never glitches them; reset drives all low
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dout <= IO_WIDTH'(`FBIO_RST_OUT);
        end else begin
            dout <= dout_d;
        end
    end

    // Read mux; reads have no side effects and unmapped offsets read zero
    always_comb begin
        reg_rdata = 32'h0000_0000;
        // Subindex 0 of each process object reports its entry count
        case (reg_addr)
            `FBIO_OFS_CTRL: reg_rdata = {16'h0000, ctrl_q};
            `FBIO_OFS_STAT: reg_rdata = {27'h0, flag_q, state_code};
            `FBIO_OFS_CODE: reg_rdata = {16'h0000, code_q};
            `FBIO_OFS_INPUT: reg_rdata = (reg_subidx == 8'h00) ? {24'h0, `FBIO_ENTRY_COUNT} : {24'h0, din};
            `FBIO_OFS_DIAG: reg_rdata = (reg_subidx == 8'h00) ? {24'h0, `FBIO_ENTRY_COUNT} : diag_word;
            `FBIO_OFS_OUTPUT: reg_rdata = (reg_subidx == 8'h00) ? {24'h0, `FBIO_ENTRY_COUNT} : {24'h0, out_q};
            `FBIO_OFS_SAFE_MODE: reg_rdata = {30'h0, safe_mode_q};
            `FBIO_OFS_SAFE_VAL: reg_rdata = {24'h0, safe_val_q};
            default: reg_rdata = 32'h0000_0000;
        endcase
    end
endmodule
`default_nettype wire

// >>> fbio_regs_sva.sv
// Port assertions for the fieldbus I/O state registers
`default_nettype none
module fbio_regs_sva #(
    parameter int IO_WIDTH = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port
    input wire logic reg_wr,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [7:0] reg_subidx,
    input wire logic [31:0] reg_rdata,
    // Field side
    input wire logic [IO_WIDTH-1:0] din,
    input wire logic [5:0] diag_flags
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // Control write and status or code selected
    wire logic ctl_wr = reg_wr && reg_addr == 16'h0120;
    wire logic st_rd = reg_addr == 16'h0130;
    wire logic cd_rd = reg_addr == 16'h0134;
    a_input_byte: assert property (reg_addr == 16'h4000 && reg_subidx == 8'h01 |-> reg_rdata == 32'(din))
        else $error("input byte wrong");
    a_diag_word: assert property (reg_addr == 16'h4001 && reg_subidx == 8'h01 |-> reg_rdata == 32'(diag_flags))
        else $error("diag word wrong");
    a_entry_count: assert property (reg_addr inside {16'h4000, 16'h4001, 16'h5000} &&
        reg_subidx == 8'h00 |-> reg_rdata == 32'h1) else $error("entry count wrong");
    a_status_code: assert property (st_rd |-> reg_rdata[3:0] inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8})
        else $error("state code illegal");
    a_status_rsvd: assert property (st_rd |-> reg_rdata[31:5] == 27'h0)
        else $error("status reserved bits set");
    a_init_request: assert property (ctl_wr && reg_wdata[3:0] == 4'h1 |=> !st_rd || reg_rdata[3:0] == 4'h1)
        else $error("init request not taken");
    a_ack_clear: assert property (ctl_wr && reg_wdata[4:0] == 5'h11 |=> !st_rd || reg_rdata[4:0] == 5'h01)
        else $error("flag not cleared");
    a_unknown_code: assert property (ctl_wr && !(reg_wdata[3:0] inside {4'h1, 4'h2, 4'h3}) |=>
        (!cd_rd || reg_rdata[15:0] == 16'h0012) && (!st_rd || reg_rdata[4])) else $error("unknown request missed");
    a_code_load: assert property (ctl_wr && !(reg_wdata[3:0] inside {4'h1, 4'h2, 4'h3}) ##1 !reg_wr ##1 cd_rd |->
        reg_rdata[15:0] == 16'h0012) else $error("unknown code not loaded");
endmodule
bind fbio_regs fbio_regs_sva #(.IO_WIDTH(IO_WIDTH)) u_sva (.sys_clk, .rst_n, .reg_wr, .reg_addr, .reg_wdata,
    .reg_subidx, .reg_rdata, .din, .diag_flags);
`default_nettype wire

// >>> fbio_master_model.sv
// Master model that issues register writes and read selects
`default_nettype none
module fbio_master_model (
    // Clock
    input wire logic sys_clk,
    // Register port towards the slave
    output logic reg_wr,
    output logic [15:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic [7:0] reg_subidx
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
        reg_subidx = 8'h00;
    end
    // One-cycle write, control bits 5 to 7 kept at zero
    task automatic wr(input logic [15:0] a, input logic [7:0] s, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_subidx <= s;
        reg_wdata <= (a == 16'h0120) ? (d & 16'hFF1F) : d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_addr <= 16'h0130; // Rest on the status register so the slave's answer shows at once
    endtask
    // Select an object for a combinational read
    task automatic sel(input logic [15:0] a, input logic [7:0] s);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_subidx <= s;
    endtask
endmodule
`default_nettype wire

// >>> tb_fbio_regs.sv
// Self-checking bench of the fieldbus I/O state registers
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; $display("Error %s exp %h got %h", nm, e, g); end end
module tb_fbio_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst_n, reg_wr, go_safeop, go_op;
    logic [15:0] reg_addr, reg_wdata;
    logic [7:0] reg_subidx, din, dout;
    logic [31:0] reg_rdata;
    logic [5:0] diag_flags;
    int n_fail = 0;
    int total_checks = 0;
    // 50 MHz clock
    always #10 sys_clk = ~sys_clk;
    fbio_master_model u_mst (.sys_clk, .reg_wr, .reg_addr, .reg_wdata, .reg_subidx);
    fbio_regs u_dut (.sys_clk, .rst_n, .reg_wr, .reg_addr, .reg_wdata, .reg_subidx, .reg_rdata, .go_safeop,
        .go_op, .din, .diag_flags, .dout);
    // Select, then compare in mid-cycle
    task automatic rd(input logic [15:0] a, input logic [7:0] s, input logic [31:0] e, input string nm);
        u_mst.sel(a, s);
        @(negedge sys_clk);
        `CHK(nm, e, reg_rdata)
    endtask
    // Outputs two edges after the cause
    task automatic out(input logic [7:0] e);
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK("dout", e, dout)
    endtask
    // One-cycle local request pulse
    task automatic local_go(input bit op);
        @(posedge sys_clk);
        go_safeop <= !op;
        go_op <= op;
        @(posedge sys_clk);
        go_safeop <= 1'b0;
        go_op <= 1'b0;
    endtask
    task automatic end_sim();
        if (n_fail == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (3000) @(posedge sys_clk);
        n_fail++;
        end_sim();
    end
    // Test sequence
    initial begin
        rst_n = 1'b0;
        go_safeop = 1'b0;
        go_op = 1'b0;
        din = 8'h81;
        diag_flags = 6'h2D;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(16'h0130, 8'h00, 32'h1, "reset state");
        rd(16'h0134, 8'h00, 32'h0, "reset code");
        rd(16'h4000, 8'h01, 32'h81, "inputs");
        rd(16'h4001, 8'h01, 32'h2D, "diag");
        rd(16'h4000, 8'h00, 32'h1, "count");
        rd(16'h4001, 8'h00, 32'h1, "count");
        rd(16'h5000, 8'h00, 32'h1, "count");
        rd(16'h7777, 8'h01, 32'h0, "unmapped");
        out(8'h00);
        u_mst.wr(16'h0120, 8'h00, 16'h0004);
        rd(16'h0134, 8'h00, 32'h12, "unknown code");
        rd(16'h0130, 8'h00, 32'h11, "error flag");
        u_mst.wr(16'h0120, 8'h00, 16'h0012);
        rd(16'h0130, 8'h00, 32'h2, "preop ack");
        rd(16'h0120, 8'h00, 32'h12, "ctrl copy");
        u_mst.wr(16'h2100, 8'h00, 16'h0001);
        out(8'hFF);
        u_mst.wr(16'h2102, 8'h01, 16'h005A);
        u_mst.wr(16'h2100, 8'h00, 16'h0003);
        out(8'h5A);
        u_mst.wr(16'h0120, 8'h00, 16'h0003);
        rd(16'h0134, 8'h00, 32'h11, "invalid code");
        local_go(1'b0);
        rd(16'h0130, 8'h00, 32'h14, "safeop");
        local_go(1'b1);
        rd(16'h0130, 8'h00, 32'h18, "op");
        u_mst.wr(16'h5000, 8'h01, 16'h00C3);
        out(8'hC3);
        rd(16'h5000, 8'h01, 32'hC3, "output byte");
        u_mst.wr(16'h0120, 8'h00, 16'h0011);
        rd(16'h0130, 8'h00, 32'h1, "init ack");
        u_mst.wr(16'h2100, 8'h00, 16'h0001);
        out(8'h5A);
        u_mst.wr(16'h0120, 8'h00, 16'h0002);
        u_mst.wr(16'h2100, 8'h00, 16'h0002);
        out(8'hC3);
        u_mst.wr(16'h2100, 8'h00, 16'h0000);
        out(8'h00);
        // Reset again in mid-run
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(16'h0130, 8'h00, 32'h1, "reset again");
        rd(16'h5000, 8'h01, 32'h0, "byte reset");
        u_mst.wr(16'h0120, 8'h00, 16'h0013);
        rd(16'h0130, 8'h00, 32'h3, "boot");
        u_mst.wr(16'h0120, 8'h00, 16'h0002);
        rd(16'h0130, 8'h00, 32'h11, "boot exit");
        rd(16'h0134, 8'h00, 32'h0, "boot code");
        end_sim();
    end
endmodule
`default_nettype wire
